/* rtl/acc_pkg.sv */
// Constants and carrier types for the codec control front.
// Assumes a 32-bit processor load/store port on the CLK_SYS domain.
package acc_pkg;
  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 32;
  localparam int          DAC_W           = 18;
  localparam int          ADC_W           = 16;
  localparam int          FIFO_DEPTH      = 16;
  localparam logic [31:0] CTRL_ONE_ADDR   = 32'h1002_0080;
  localparam logic [31:0] CTRL_TWO_ADDR   = 32'h1002_0084;
  localparam logic [31:0] CTRL_ONE_RESET  = 32'h021B_2302;
  localparam logic [31:0] CTRL_TWO_RESET  = 32'h0017_0803;
  localparam logic [31:0] CTRL_ONE_WMASK  = 32'h3FFF_FFFF;
  localparam logic [31:0] CTRL_TWO_WMASK  = 32'hFFFF_FFFF;
  localparam int          LINE_EN_BIT     = 29;
  localparam int          MIC_EN_BIT      = 28;
  localparam int          IN_HP_SW_BIT    = 27;
  localparam int          ADC_ALIGN_SHIFT = DAC_W - ADC_W;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } acc_mem_req_t;

  typedef struct packed {
    logic             valid;
    logic [DAC_W-1:0] data;
  } acc_play_t;

  typedef struct packed {
    logic             valid;
    logic [ADC_W-1:0] data;
  } acc_rec_t;
endpackage

/* rtl/acc_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
// Assumes both sides on one clock; in_ready is registered.
`timescale 1ns/1ps
module acc_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("acc_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign out_valid = (count != '0);
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      count    <= next_count;
      // Registered ready keeps the source decoupled from the drain's timing
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

/* rtl/acc_codec_ctrl.sv */
// Digital control front of the on-chip audio codec: two control words on the
// processor load/store port, playback/record sample paths and headphone mix.
// Assumes all ports are driven by logic on CLK_SYS; the controller enables
// codec access before writing the first control word.
//
// Summary of operation
// RULE_01 - Playback samples are 18 bits to the DAC; record samples 16 bits.
// RULE_02 - Both control words sit in memory-mapped I/O, reached by loads/stores.
// RULE_03 - First control word: 32-bit read-write at 0x10020080, resets to 0x021B2302.
// RULE_04 - Second control word: 32-bit read-write at 0x10020084, resets to 0x00170803.
// RULE_05 - Second word holds mic gain, line gain, headphone volume, sample rate.
// RULE_06 - Software enables codec access in the controller before writing word one.
// RULE_07 - Bits 31:30 of the first word ignore writes and read zero.
// RULE_08 - First word bit 29 enables the line input.
// RULE_09 - First word bit 28 enables the microphone input.
// RULE_10 - First word bit 27 routes input audio through the mixer to headphone.
// RULE_11 - Writable fields read back last written value, else reset value.
`timescale 1ns/1ps
module acc_codec_ctrl
  import acc_pkg::*;
#(
  parameter int PLAY_DEPTH = acc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                CLK_SYS,
  input  wire logic                SRST,
  // Processor load/store port
  input  wire acc_pkg::acc_mem_req_t MEM_REQ,
  output logic [acc_pkg::DATA_W-1:0] MEM_RDATA,
  output logic                       MEM_RVALID,
  // Analog control words and decoded enables
  output logic [acc_pkg::DATA_W-1:0] CTRL_ONE,
  output logic [acc_pkg::DATA_W-1:0] CTRL_TWO,
  output logic                       LINE_IN_EN,
  output logic                       MIC_IN_EN,
  output logic                       IN_TO_HP_SW,
  // Playback stream from the audio interface controller
  input  wire acc_pkg::acc_play_t    PLAY_IN,
  output logic                       PLAY_READY,
  // Samples toward the DAC and the headphone mixer
  output acc_pkg::acc_play_t         DAC_OUT,
  input  wire logic                  DAC_READY,
  output logic [acc_pkg::DAC_W-1:0]  HP_MIX,
  // Record stream from the ADC toward the controller
  input  wire acc_pkg::acc_rec_t     ADC_IN,
  output acc_pkg::acc_rec_t          REC_OUT
);
  import acc_pkg::*;

  generate
    if (PLAY_DEPTH < 2) begin : g_bad
      $error("acc_codec_ctrl: PLAY_DEPTH too small");
    end
  endgenerate

  logic [DATA_W-1:0] codec_control_one;
  logic [DATA_W-1:0] codec_control_two;
  logic              hit_one;
  logic              hit_two;
  logic              fifo_valid;
  logic [DAC_W-1:0]  fifo_data;
  logic              fifo_take;
  logic              fifo_ready;
  logic [ADC_W-1:0]  last_input;
  logic [DAC_W:0]    next_mix;

  // Full 32-bit compare: only the two documented words answer
  assign hit_one = (MEM_REQ.addr == CTRL_ONE_ADDR); // RULE_02
  assign hit_two = (MEM_REQ.addr == CTRL_TWO_ADDR); // RULE_02

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      codec_control_one <= CTRL_ONE_RESET; // RULE_03
      codec_control_two <= CTRL_TWO_RESET; // RULE_04
    end else if (MEM_REQ.wr) begin
      // Access enable lives in the controller; writes here are not gated
      if (hit_one) begin
        codec_control_one <= MEM_REQ.wdata & CTRL_ONE_WMASK; // RULE_07
      end
      if (hit_two) begin
        // Gain, volume and rate fields pass straight to the analog side
        codec_control_two <= MEM_REQ.wdata & CTRL_TWO_WMASK; // RULE_05
      end
    end
  end

  // Read data one cycle after the load; unmapped addresses read zero
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      MEM_RDATA  <= '0;
      MEM_RVALID <= 1'b0;
    end else begin
      MEM_RVALID <= MEM_REQ.rd;
      if (MEM_REQ.rd) begin
        if (hit_one) begin
          MEM_RDATA <= codec_control_one & CTRL_ONE_WMASK; // RULE_11
        end else if (hit_two) begin
          MEM_RDATA <= codec_control_two; // RULE_11
        end else begin
          MEM_RDATA <= '0;
        end
      end
    end
  end

  // Outputs are registered copies, so they trail the stored word by one cycle
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      CTRL_ONE    <= CTRL_ONE_RESET;
      CTRL_TWO    <= CTRL_TWO_RESET;
      LINE_IN_EN  <= CTRL_ONE_RESET[LINE_EN_BIT];
      MIC_IN_EN   <= CTRL_ONE_RESET[MIC_EN_BIT];
      IN_TO_HP_SW <= CTRL_ONE_RESET[IN_HP_SW_BIT];
    end else begin
      CTRL_ONE    <= codec_control_one;
      CTRL_TWO    <= codec_control_two;
      LINE_IN_EN  <= codec_control_one[LINE_EN_BIT]; // RULE_08
      MIC_IN_EN   <= codec_control_one[MIC_EN_BIT]; // RULE_09
      IN_TO_HP_SW <= codec_control_one[IN_HP_SW_BIT]; // RULE_10
    end
  end

  acc_fifo #(
    .WIDTH (DAC_W),
    .DEPTH (PLAY_DEPTH)
  ) u_play_fifo (
    .clk       (CLK_SYS),
    .srst      (SRST),
    .in_valid  (PLAY_IN.valid),
    .in_data   (PLAY_IN.data),
    .in_ready  (fifo_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_take)
  );

  assign PLAY_READY = fifo_ready;
  // DAC stage refills when empty or when its current sample is accepted
  assign fifo_take  = !DAC_OUT.valid || DAC_READY;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      DAC_OUT <= '0;
    end else if (fifo_take) begin
      DAC_OUT.valid <= fifo_valid;
      if (fifo_valid) begin
        DAC_OUT.data <= fifo_data; // RULE_01
      end
    end
  end

  // Record samples only leave while some input path is enabled
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      REC_OUT    <= '0;
      last_input <= '0;
    end else begin
      REC_OUT.valid <= ADC_IN.valid && (LINE_IN_EN || MIC_IN_EN); // RULE_08 RULE_09
      if (ADC_IN.valid) begin
        REC_OUT.data <= ADC_IN.data; // RULE_01
        last_input   <= (LINE_IN_EN || MIC_IN_EN) ? ADC_IN.data : '0;
      end
    end
  end

  // Mixer: DAC sample plus the MSB-aligned input sample, saturated
  always_comb begin
    next_mix = {DAC_OUT.data[DAC_W-1], DAC_OUT.data};
    if (IN_TO_HP_SW) begin
      next_mix = next_mix + {last_input[ADC_W-1],
                             last_input, {ADC_ALIGN_SHIFT{1'b0}}}; // RULE_10
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      HP_MIX <= '0;
    end else if (next_mix[DAC_W] != next_mix[DAC_W-1]) begin
      HP_MIX <= {next_mix[DAC_W], {(DAC_W-1){~next_mix[DAC_W]}}};
    end else begin
      HP_MIX <= next_mix[DAC_W-1:0];
    end
  end
endmodule

/* sim/acc_codec_ctrl_monitor.sv */
// Port checker for the codec control front.
// Assumes one clock domain; bound into acc_codec_ctrl.
`timescale 1ns/1ps
module acc_codec_ctrl_monitor
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic              CLK_SYS,
  input wire logic              SRST,
  // Watched ports
  input wire acc_mem_req_t      MEM_REQ,
  input wire logic [DATA_W-1:0] MEM_RDATA,
  input wire logic              MEM_RVALID,
  input wire logic [DATA_W-1:0] CTRL_ONE,
  input wire logic              LINE_IN_EN,
  input wire logic              MIC_IN_EN,
  input wire logic              IN_TO_HP_SW,
  input wire acc_play_t         DAC_OUT,
  input wire logic              DAC_READY,
  input wire acc_rec_t          ADC_IN,
  input wire acc_rec_t          REC_OUT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  rd_pulse_a: assert property (MEM_RVALID == $past(MEM_REQ.rd))
    else $error("read valid off");
  top_zero_a: assert property (CTRL_ONE[31:30] == 2'h0)
    else $error("top bits set");
  line_bit_a: assert property (LINE_IN_EN == CTRL_ONE[29])
    else $error("line enable off");
  mic_bit_a: assert property (MIC_IN_EN == CTRL_ONE[28])
    else $error("mic enable off");
  mix_sw_a: assert property (IN_TO_HP_SW == CTRL_ONE[27])
    else $error("mix switch off");
  two_back_a: assert property (MEM_REQ.wr && MEM_REQ.addr == CTRL_TWO_ADDR ##1
    MEM_REQ.rd && !MEM_REQ.wr && MEM_REQ.addr == CTRL_TWO_ADDR
    |=> MEM_RDATA == $past(MEM_REQ.wdata, 2)) else $error("word two readback");
  hole_zero_a: assert property (MEM_REQ.rd && MEM_REQ.addr != CTRL_ONE_ADDR
    && MEM_REQ.addr != CTRL_TWO_ADDR |=> MEM_RDATA == 32'h0) else $error("hole read");
  rec_pass_a: assert property (ADC_IN.valid && (LINE_IN_EN || MIC_IN_EN) |=>
    REC_OUT.valid && REC_OUT.data == $past(ADC_IN.data)) else $error("record lost");
  rec_block_a: assert property (!(ADC_IN.valid && (LINE_IN_EN || MIC_IN_EN))
    |=> !REC_OUT.valid) else $error("record leak");
  dac_hold_a: assert property (DAC_OUT.valid && !DAC_READY |=>
    DAC_OUT.valid && $stable(DAC_OUT.data)) else $error("dac sample moved");
  rdata_hold_a: assert property (!$past(MEM_REQ.rd) |-> $stable(MEM_RDATA))
    else $error("read data moved");
endmodule
bind acc_codec_ctrl acc_codec_ctrl_monitor acc_codec_ctrl_monitor_i (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA),
  .MEM_RVALID(MEM_RVALID), .CTRL_ONE(CTRL_ONE), .LINE_IN_EN(LINE_IN_EN),
  .MIC_IN_EN(MIC_IN_EN), .IN_TO_HP_SW(IN_TO_HP_SW), .DAC_OUT(DAC_OUT),
  .DAC_READY(DAC_READY), .ADC_IN(ADC_IN), .REC_OUT(REC_OUT));

/* sim/acc_aic_model.sv */
// Audio interface controller stand-in streaming playback samples.
// Assumes the front's PLAY_READY handshake on the same clock.
`timescale 1ns/1ps
module acc_aic_model
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic   clk,
  input wire logic   srst,
  // Bench control
  input wire logic   go,
  input wire logic   slow,
  // Playback stream
  output acc_play_t  play,
  input wire logic   ready,
  output logic [31:0] sent
);
  logic             vld;
  logic             tick;
  logic [DAC_W-1:0] smp;
  assign smp = DAC_W'(sent * 32'h9E37 + 32'h5);
  // Idle data shows the inverse so a stale sample cannot pass
  assign play = '{vld, vld ? smp : ~smp};
  always_ff @(posedge clk) begin
    if (srst) begin
      vld <= 1'h0;
      tick <= 1'h0;
      sent <= 32'h0;
    end else begin
      tick <= ~tick;
      if (vld && ready) sent <= sent + 32'h1;
      if (!vld || ready) vld <= go && !(slow && tick);
    end
  end
endmodule

/* sim/acc_codec_ctrl_tb_top.sv */
// Bench for the codec control front: registers, record and playback paths.
// Assumes acc_aic_model as playback source; clock 40 MHz.
`timescale 1ns/1ps
module acc_codec_ctrl_tb_top;
  import acc_pkg::*;
  logic CLK_SYS, SRST = 1'h1, DAC_READY = 1'h0, go = 1'h0, slow = 1'h0;
  logic MEM_RVALID, LINE_IN_EN, MIC_IN_EN, IN_TO_HP_SW, PLAY_READY;
  logic access_en = 1'h0;
  logic [31:0] MEM_RDATA, CTRL_ONE, CTRL_TWO, sent, q, v;
  logic [17:0] HP_MIX;
  logic [15:0] rnd = 16'h0024;
  acc_mem_req_t MEM_REQ = '0;
  acc_play_t PLAY_IN, DAC_OUT;
  acc_rec_t ADC_IN = '0, REC_OUT;
  int err_total, check_count, k;
  acc_codec_ctrl acc_codec_ctrl_i (.CLK_SYS(CLK_SYS), .SRST(SRST), .MEM_REQ(MEM_REQ),
    .MEM_RDATA(MEM_RDATA), .MEM_RVALID(MEM_RVALID), .CTRL_ONE(CTRL_ONE),
    .CTRL_TWO(CTRL_TWO), .LINE_IN_EN(LINE_IN_EN), .MIC_IN_EN(MIC_IN_EN),
    .IN_TO_HP_SW(IN_TO_HP_SW), .PLAY_IN(PLAY_IN), .PLAY_READY(PLAY_READY),
    .DAC_OUT(DAC_OUT), .DAC_READY(DAC_READY), .HP_MIX(HP_MIX), .ADC_IN(ADC_IN),
    .REC_OUT(REC_OUT));
  acc_aic_model acc_aic_model_i (.clk(CLK_SYS), .srst(SRST), .go(go), .slow(slow),
    .play(PLAY_IN), .ready(PLAY_READY), .sent(sent));
  initial begin
    CLK_SYS = 1'h0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [17:0] exp_smp(input int unsigned n);
    return 18'(n * 32'h9E37 + 32'h5);
  endfunction
  // Headphone mix: DAC sample plus input sample scaled to 18 bits, saturated
  function automatic logic [17:0] exp_mix(input logic [17:0] d, input logic [15:0] s);
    int t;
    t = int'($signed(d)) + int'($signed(s)) * 4;
    if (t > 131071) t = 131071;
    if (t < -131072) t = -131072;
    return 18'(t);
  endfunction
  task automatic roll();
    rnd = nx(rnd);
    v[31:16] = rnd;
    rnd = nx(rnd);
    v[15:0] = rnd;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Request stays up until the next call or an explicit idle, so back-to-back
  // accesses never clear and reassert the strobe in one time step
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    if (w && a == CTRL_ONE_ADDR) chk(32'(access_en), 32'h1);
    MEM_REQ = '{w, !w, a, d};
    @(posedge CLK_SYS) #2;
    q = MEM_RDATA;
    if (!w) chk(32'(MEM_RVALID), 32'h1);
  endtask
  task automatic mix_case(input logic [17:0] dac, input logic [15:0] s);
    bus(1, CTRL_ONE_ADDR, 32'h1800_0000);
    MEM_REQ = '0;
    @(posedge CLK_SYS) #2;
    ADC_IN = '{1'h1, s};
    @(posedge CLK_SYS) #2;
    ADC_IN = '0;
    @(posedge CLK_SYS) #2;
    chk(32'(HP_MIX), 32'(exp_mix(dac, s)));
    bus(1, CTRL_ONE_ADDR, 32'h1000_0000);
    MEM_REQ = '0;
    repeat (2) @(posedge CLK_SYS);
    #2 chk(32'(HP_MIX), 32'(exp_mix(dac, 16'h0)));
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge CLK_SYS)
    if (!SRST && DAC_OUT.valid && DAC_READY) begin
      chk(32'(DAC_OUT.data), 32'(exp_smp(k)));
      k++;
    end
  initial begin
    #125000;
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge CLK_SYS);
    #2 SRST = 1'h0;
    bus(0, CTRL_ONE_ADDR, 0);
    chk(q, 32'h021B_2302);
    chk(CTRL_TWO, 32'h0017_0803);
    chk(32'({LINE_IN_EN, MIC_IN_EN, IN_TO_HP_SW}), 32'h0);
    $display("reset values done");
    for (int i = 0; i < 9; i++) begin
      roll();
      if (i == 0) v = 32'hFFFF_FFFF;
      access_en = 1'h1;
      bus(1, CTRL_ONE_ADDR, v);
      bus(0, CTRL_ONE_ADDR, 0);
      chk(q, v & 32'h3FFF_FFFF);
      chk(CTRL_ONE, v & 32'h3FFF_FFFF);
      chk(32'({LINE_IN_EN, MIC_IN_EN, IN_TO_HP_SW}), 32'(v[29:27]));
      roll();
      bus(1, CTRL_TWO_ADDR, v);
      bus(0, CTRL_TWO_ADDR, 0);
      chk(q, v);
      chk(CTRL_TWO, v);
    end
    bus(1, 32'h1002_0088, 32'hFFFF_FFFF);
    bus(0, 32'h1002_0088, 0);
    chk(q, 32'h0);
    bus(0, CTRL_TWO_ADDR, 0);
    chk(q, v);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      bus(1, CTRL_ONE_ADDR, {2'h0, i[1:0], 28'h0});
      MEM_REQ = '0;
      @(posedge CLK_SYS) #2;
      roll();
      ADC_IN = '{1'h1, v[15:0]};
      @(posedge CLK_SYS) #2;
      ADC_IN = '0;
      chk(32'(REC_OUT.valid), 32'(i != 0));
      if (i != 0) chk(32'(REC_OUT.data), 32'(v[15:0]));
    end
    $display("record test done");
    roll();
    mix_case(18'h0, v[15:0]);
    go = 1'h1;
    repeat (40) @(posedge CLK_SYS);
    #2 chk(32'(PLAY_READY), 32'h0);
    for (int i = 0; i < 300; i++) begin
      @(posedge CLK_SYS) #2;
      rnd = nx(rnd);
      DAC_READY = rnd[0] | rnd[3];
      slow = rnd[5];
      if (i == 200) go = 1'h0;
    end
    DAC_READY = 1'h1;
    repeat (30) @(posedge CLK_SYS);
    #2 chk(32'(k), sent);
    chk(32'(PLAY_READY), 32'h1);
    $display("playback test done");
    // Last DAC sample stays on the mixer; full-scale inputs drive saturation
    mix_case(exp_smp(k - 1), 16'h7FFF);
    mix_case(exp_smp(k - 1), 16'h8000);
    $display("mix test done");
    SRST = 1'h1;
    repeat (3) @(posedge CLK_SYS);
    #2 SRST = 1'h0;
    bus(0, CTRL_ONE_ADDR, 0);
    chk(q, 32'h021B_2302);
    bus(0, CTRL_TWO_ADDR, 0);
    chk(q, 32'h0017_0803);
    MEM_REQ = '0;
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
